// File: dcc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_channel #(
    parameter int ADR_W   = 6,
    parameter int N_CH    = 8,
    parameter int CHAN_ID = 2
) (
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    input  wire logic [ADR_W-1:0]  WB_ADR_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic              WB_WE_I,
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    output logic                   WB_ACK_O,
    output logic                   M_CYC_O,
    output logic                   M_STB_O,
    output logic                   M_WE_O,
    output logic      [31:0]       M_ADR_O,
    output logic      [3:0]        M_SEL_O,
    output logic      [31:0]       M_DAT_O,
    input  wire logic [31:0]       M_DAT_I,
    input  wire logic              M_ACK_I,
    input  wire logic              DREQ,
    input  wire logic [N_CH-1:0]   PEER_REQ,
    input  wire logic [3*N_CH-1:0] PEER_PRIO,
    input  wire logic              SYS_GNT,
    output logic                   BUS_REQ,
    output logic                   BUS_LOCK,
    output logic      [2:0]        BUS_PRIO,
    output logic                   IRQ
);

    generate
        if (CHAN_ID >= N_CH || ADR_W < 6) begin : g_bad
            $error("dcc_channel: CHAN_ID or ADR_W out of range");
        end
    endgenerate

    typedef enum logic [5:0] {
        S_OFF  = 6'h01,
        S_WAIT = 6'h02,
        S_ARB  = 6'h04,
        S_RD   = 6'h08,
        S_WR   = 6'h10,
        S_GAP  = 6'h20
    } dcc_state_e;

    dcc_state_e  st_q;
    dcc_state_e  st_d;
    logic [15:0] src_lo_q;
    logic [15:0] src_hi_q;
    logic [15:0] dst_lo_q;
    logic [15:0] dst_hi_q;
    logic [15:0] thr_q;
    logic [15:0] len_q;
    logic [15:0] ctrl_q;
    logic [15:0] idx_q;
    logic [15:0] nidx;
    logic [15:0] aidx;
    logic [31:0] data_q;
    logic [31:0] rdat;
    logic [31:0] src_a;
    logic [31:0] dst_a;
    logic [1:0]  wid;
    logic        ack_q;
    logic        wb_hit;
    logic        wr_en;
    logic        mapped;
    logic [3:0]  slot;
    logic        sw_ctrl_wr;
    logic        req_s1_q;
    logic        req_s2_q;
    logic        req_s3_q;
    logic        pend_q;
    logic        req_ok;
    logic        en;
    logic        pace;
    logic        fill;
    logic        hold;
    logic        yield;
    logic        restart;
    logic        last;
    logic        wr_done;
    logic        win;

    // byte lanes of one item
    function automatic logic [3:0] lane_sel(input logic [1:0] w, input logic [1:0] a);
        case (w)
            dcc_pkg::W_BYTE: lane_sel = 4'(4'h1 << a);
            dcc_pkg::W_HALF: lane_sel = 4'(4'h3 << a);
            default:         lane_sel = 4'hF;
        endcase
    endfunction : lane_sel

    // start plus index times step; reserved width steps like a byte
    function automatic logic [31:0] addr_calc(input logic [31:0] base,
                                              input logic [15:0] idx,
                                              input logic        inc,
                                              input logic [1:0]  w);
        logic [31:0] off;
        off = {16'h0000, idx};
        if (!inc)
            addr_calc = base;
        else if (w == dcc_pkg::W_WORD)
            addr_calc = base + (off << 2);
        else if (w == dcc_pkg::W_HALF)
            addr_calc = base + (off << 1);
        else
            addr_calc = base + off;
    endfunction : addr_calc

    // byte-enable merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] d,
                                            input logic [1:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // channel wins unless a peer is higher, or equal and lower numbered
    function automatic logic arb_win(input logic [N_CH-1:0]   req,
                                     input logic [3*N_CH-1:0] prio,
                                     input logic [2:0]        mine);
        logic ok;
        ok = 1'b1;
        for (int j = 0; j < N_CH; j++) begin
            if (j != CHAN_ID && req[j]) begin
                if (prio[3*j +: 3] > mine)
                    ok = 1'b0;
                else if (prio[3*j +: 3] == mine && j < CHAN_ID)
                    ok = 1'b0;
            end
        end
        arb_win = ok;
    endfunction : arb_win

    // control decode
    assign en      = ctrl_q[dcc_pkg::B_ON];
    assign pace    = ctrl_q[dcc_pkg::B_PACE];
    assign fill    = ctrl_q[dcc_pkg::B_FILL];
    assign wid     = ctrl_q[dcc_pkg::B_WID +: 2];
    assign restart = ctrl_q[dcc_pkg::B_CIRC] & pace;
    // keeps the bus between items when unpaced: fill or blocking; a fill never yields
    assign hold    = !pace & (fill | !ctrl_q[dcc_pkg::B_IDLE]);
    assign yield   = !pace & !fill & ctrl_q[dcc_pkg::B_IDLE];
    assign last    = idx_q == len_q;
    assign wr_done = (st_q == S_WR) & M_STB_O & M_ACK_I;
    assign nidx    = last ? 16'h0000 : 16'(idx_q + 16'h0001);
    assign aidx    = wr_done ? nidx : idx_q;
    assign src_a   = addr_calc({src_hi_q, src_lo_q}, aidx, ctrl_q[dcc_pkg::B_SINC], wid);
    assign dst_a   = addr_calc({dst_hi_q, dst_lo_q}, aidx, ctrl_q[dcc_pkg::B_DINC], wid);
    assign win     = arb_win(PEER_REQ, PEER_PRIO, ctrl_q[dcc_pkg::B_PRIO +: 3]);
    assign req_ok  = ctrl_q[dcc_pkg::B_EDGE] ? pend_q : req_s2_q;
    // read data shifted to bit 0 as it arrives
    assign rdat    = 32'(M_DAT_I >> {M_ADR_O[1:0], 3'b000});

    // register slave decode
    assign wb_hit     = WB_CYC_I & WB_STB_I & !ack_q;
    assign wr_en      = wb_hit & WB_WE_I;
    assign slot       = WB_ADR_I[5:2];
    assign mapped     = (WB_ADR_I[1:0] == 2'h0) && ((WB_ADR_I >> 6) == '0) && !slot[0];
    assign sw_ctrl_wr = wr_en & mapped & (slot == dcc_pkg::SL_CTRL);

    // request pin synchroniser, third stage for edge detect
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else if (CE) begin
            req_s1_q <= DREQ;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    // edge request pending; a new edge beats the consume
    always_ff @(posedge MCLK) begin
        if (!RST_B)
            pend_q <= 1'b0;
        else if (CE) begin
            if (req_s2_q & !req_s3_q)
                pend_q <= 1'b1;
            else if (st_q == S_WAIT && st_d == S_ARB)
                pend_q <= 1'b0;
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_OFF: begin
                if (en)
                    st_d = pace ? S_WAIT : S_ARB;
            end
            S_WAIT: begin
                if (!en)
                    st_d = S_OFF;
                else if (req_ok)
                    st_d = S_ARB;
            end
            S_ARB: begin
                if (!en)
                    st_d = S_OFF;
                else if (win & SYS_GNT)
                    st_d = (fill && idx_q != 16'h0000) ? S_WR : S_RD;
            end
            S_RD: begin
                if (M_ACK_I)
                    st_d = S_WR;
            end
            S_WR: begin
                if (!M_ACK_I)
                    st_d = S_WR;
                else if (!en || (last && !restart))
                    st_d = S_OFF;
                else if (pace)
                    st_d = S_WAIT;
                else if (yield)
                    st_d = S_GAP;
                else
                    st_d = fill ? S_WR : S_RD;
            end
            S_GAP: begin
                st_d = en ? S_ARB : S_OFF;
            end
            default: st_d = S_OFF;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B)
            st_q <= S_OFF;
        else if (CE)
            st_q <= st_d;
    end

    // system bus master; one access at a time, stb held to ack
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            M_CYC_O <= 1'b0;
            M_STB_O <= 1'b0;
            M_WE_O  <= 1'b0;
            M_ADR_O <= 32'h00000000;
            M_SEL_O <= 4'h0;
            M_DAT_O <= 32'h00000000;
        end else if (CE) begin
            if (st_d == S_RD && st_q != S_RD) begin
                M_CYC_O <= 1'b1;
                M_STB_O <= 1'b1;
                M_WE_O  <= 1'b0;
                M_ADR_O <= src_a;
                M_SEL_O <= lane_sel(wid, src_a[1:0]);
            end else if (st_d == S_WR && (st_q != S_WR || M_ACK_I)) begin
                M_CYC_O <= 1'b1;
                M_STB_O <= 1'b1;
                M_WE_O  <= 1'b1;
                M_ADR_O <= dst_a;
                M_SEL_O <= lane_sel(wid, dst_a[1:0]);
                // fill reuses the single fetched value
                M_DAT_O <= 32'(((st_q == S_RD) ? rdat : data_q) << {dst_a[1:0], 3'b000});
            end else if (st_d != S_RD && st_d != S_WR) begin
                M_CYC_O <= 1'b0;
                M_STB_O <= 1'b0;
                M_WE_O  <= 1'b0;
            end
        end
    end

    // fetched item, kept at bit 0
    always_ff @(posedge MCLK) begin
        if (!RST_B)
            data_q <= 32'h00000000;
        else if (CE && st_q == S_RD && M_ACK_I)
            data_q <= rdat;
    end

    // arbitration outputs; lock keeps lower masters and peers out
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            BUS_REQ  <= 1'b0;
            BUS_LOCK <= 1'b0;
            BUS_PRIO <= 3'h0;
        end else if (CE) begin
            BUS_REQ  <= st_d == S_ARB || st_d == S_RD || st_d == S_WR;
            BUS_LOCK <= en & hold;
            BUS_PRIO <= ctrl_q[dcc_pkg::B_PRIO +: 3];
        end
    end

    // item index and threshold interrupt pulse
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            idx_q <= dcc_pkg::RST_VAL;
            IRQ   <= 1'b0;
        end else if (CE) begin
            IRQ <= wr_done & ctrl_q[dcc_pkg::B_IRQEN] & (thr_q == idx_q);
            if (wr_done)
                idx_q <= nidx;
        end
    end

    // software registers; a software write to control beats the auto clear
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            src_lo_q <= dcc_pkg::RST_VAL;
            src_hi_q <= dcc_pkg::RST_VAL;
            dst_lo_q <= dcc_pkg::RST_VAL;
            dst_hi_q <= dcc_pkg::RST_VAL;
            thr_q    <= dcc_pkg::RST_VAL;
            len_q    <= dcc_pkg::RST_VAL;
            ctrl_q   <= dcc_pkg::RST_VAL;
        end else if (CE) begin
            if (wr_done && last && !restart)
                ctrl_q[dcc_pkg::B_ON] <= 1'b0;
            if (wr_en && mapped) begin
                case (slot)
                    dcc_pkg::SL_SRC_LO:
                        src_lo_q <= merge16(src_lo_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_SRC_HI:
                        src_hi_q <= merge16(src_hi_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_DST_LO:
                        dst_lo_q <= merge16(dst_lo_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_DST_HI:
                        dst_hi_q <= merge16(dst_hi_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_THR:
                        thr_q <= merge16(thr_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_LEN:
                        len_q <= merge16(len_q, WB_DAT_I[15:0], WB_SEL_I[1:0]);
                    dcc_pkg::SL_CTRL:
                        ctrl_q <= merge16(ctrl_q, WB_DAT_I[15:0], WB_SEL_I[1:0])
                                  & dcc_pkg::CTRL_MSK;
                    default: ;
                endcase
            end
        end
    end

    // slave answer one cycle after the request; unmapped reads zero
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ack_q    <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else if (CE) begin
            ack_q <= wb_hit;
            if (wb_hit) begin
                WB_DAT_O <= 32'h00000000;
                if (mapped) begin
                    case (slot)
                        dcc_pkg::SL_SRC_LO: WB_DAT_O[15:0] <= src_lo_q;
                        dcc_pkg::SL_SRC_HI: WB_DAT_O[15:0] <= src_hi_q;
                        dcc_pkg::SL_DST_LO: WB_DAT_O[15:0] <= dst_lo_q;
                        dcc_pkg::SL_DST_HI: WB_DAT_O[15:0] <= dst_hi_q;
                        dcc_pkg::SL_THR:    WB_DAT_O[15:0] <= thr_q;
                        dcc_pkg::SL_LEN:    WB_DAT_O[15:0] <= len_q;
                        dcc_pkg::SL_CTRL:   WB_DAT_O[15:0] <= ctrl_q;
                        dcc_pkg::SL_IDX:    WB_DAT_O[15:0] <= idx_q;
                        default: ;
                    endcase
                end
            end
        end
    end

    assign WB_ACK_O = ack_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    irq_gate_a: assert property ($rose(IRQ) |-> $past(ctrl_q[dcc_pkg::B_IRQEN]))
        else $error("interrupt without enable");
    irq_match_a: assert property ($rose(IRQ) |-> $past(thr_q == idx_q))
        else $error("interrupt without threshold match");
    idx_wrap_a: assert property (CE && wr_done && last |=> idx_q == 16'h0000)
        else $error("index not zero after last item");
    stop_clear_a: assert property (CE && wr_done && last && !restart && !sw_ctrl_wr
                                   |=> !ctrl_q[dcc_pkg::B_ON])
        else $error("enable not cleared at completion");
    circ_keep_a: assert property (CE && wr_done && last && restart && en
                                  && !sw_ctrl_wr |=> ctrl_q[dcc_pkg::B_ON] && st_q == S_WAIT)
        else $error("circular channel did not restart");
    yield_gap_a: assert property (CE && wr_done && en && !last && yield
                                  |=> !M_CYC_O && st_q == S_GAP ##1 !M_CYC_O)
        else $error("no idle cycle after store");
    fill_lock_a: assert property (CE && en && fill && !pace |=> BUS_LOCK)
        else $error("fill not locked");
    fill_write_a: assert property (CE && wr_done && en && fill && !pace && !last
                                   |=> M_CYC_O && M_WE_O)
        else $error("fill fetched the source again");
    ack_pulse_a: assert property (CE && WB_ACK_O |=> !WB_ACK_O)
        else $error("slave ack longer than one cycle");

    irq_seen_c: cover property ($rose(IRQ));
    circ_seen_c: cover property (wr_done && last && restart);
    gap_seen_c: cover property (st_q == S_GAP);
    fill_seen_c: cover property (wr_done && fill && idx_q == 16'h0002);

endmodule : dcc_channel
`default_nettype wire

// File: dcc_pkg.sv
package dcc_pkg;
    // printed register locations, kept as register indices
    localparam logic [31:0] BLK_BASE   = 32'h50003520;
    localparam logic [31:0] OFS_SRC_LO = 32'h50003520;
    localparam logic [31:0] OFS_SRC_HI = 32'h50003522;
    localparam logic [31:0] OFS_DST_LO = 32'h50003524;
    localparam logic [31:0] OFS_DST_HI = 32'h50003526;
    localparam logic [31:0] OFS_THR    = 32'h50003528;
    localparam logic [31:0] OFS_LEN    = 32'h5000352A;
    localparam logic [31:0] OFS_CTRL   = 32'h5000352C;
    localparam logic [31:0] OFS_IDX    = 32'h5000352E;
    // bus slot = index minus base; byte address is four times it
    localparam logic [3:0] SL_SRC_LO = 4'(OFS_SRC_LO - BLK_BASE);
    localparam logic [3:0] SL_SRC_HI = 4'(OFS_SRC_HI - BLK_BASE);
    localparam logic [3:0] SL_DST_LO = 4'(OFS_DST_LO - BLK_BASE);
    localparam logic [3:0] SL_DST_HI = 4'(OFS_DST_HI - BLK_BASE);
    localparam logic [3:0] SL_THR    = 4'(OFS_THR - BLK_BASE);
    localparam logic [3:0] SL_LEN    = 4'(OFS_LEN - BLK_BASE);
    localparam logic [3:0] SL_CTRL   = 4'(OFS_CTRL - BLK_BASE);
    localparam logic [3:0] SL_IDX    = 4'(OFS_IDX - BLK_BASE);
    localparam logic [15:0] RST_VAL  = 16'h0000;
    localparam logic [15:0] CTRL_MSK = 16'h3FFF;
    // control word fields
    localparam int B_ON    = 0;
    localparam int B_WID   = 1;
    localparam int B_IRQEN = 3;
    localparam int B_PACE  = 4;
    localparam int B_DINC  = 5;
    localparam int B_SINC  = 6;
    localparam int B_CIRC  = 7;
    localparam int B_PRIO  = 8;
    localparam int B_IDLE  = 11;
    localparam int B_FILL  = 12;
    localparam int B_EDGE  = 13;
    // item width codes
    localparam logic [1:0] W_BYTE = 2'h0;
    localparam logic [1:0] W_HALF = 2'h1;
    localparam logic [1:0] W_WORD = 2'h2;
endpackage : dcc_pkg

// File: dcc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_mem_model (
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        CYC,
    input  wire logic        STB,
    input  wire logic [31:0] ADR,
    input  wire logic [1:0]  DLY,
    output logic             ACK,
    output logic      [31:0] DAT
);
    logic [1:0] cnt_q;
    // acks after a varying wait; idle data toggles so stale reads show up
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            ACK   <= 1'b0;
            DAT   <= 32'h0000_0000;
            cnt_q <= 2'h0;
        end else if (CYC && STB && !ACK && cnt_q >= DLY) begin
            ACK   <= 1'b1;
            DAT   <= {4{ADR[7:0] ^ 8'h5A}};
            cnt_q <= 2'h0;
        end else begin
            ACK   <= 1'b0;
            DAT   <= ~DAT;
            cnt_q <= (CYC && STB && !ACK) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule : dcc_mem_model
`default_nettype wire

// File: dcc_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module dcc_channel_tb_top;
    logic        MCLK, RST_B, wb_we, wb_cyc, wb_stb, wb_ack, m_cyc, m_stb, m_we, m_ack;
    logic        dreq, gnt, lock, irq, lcyc, breq;
    logic [5:0]  wb_adr;
    logic [31:0] wb_wd, wb_rd, m_adr, m_do, m_di, r, lrd, e;
    logic [3:0]  m_sel;
    logic [7:0]  peer_req;
    logic [23:0] peer_prio;
    logic [2:0]  prio_o;
    logic [1:0]  wd;
    logic [15:0] q, v;
    logic [31:0] rq[$], wq[$];
    int          failures, num_checks, irq_n, falls, nolock, cyc_n, k;
    logic [15:0] c_t[7] = '{16'h026D, 16'h0B41, 16'h012B, 16'h1865, 16'h0871, 16'h2075, 16'h00FB};
    logic [15:0] n_t[7] = '{16'h3, 16'h2, 16'h0, 16'h4, 16'h2, 16'h2, 16'h1};
    logic [15:0] t_t[7] = '{16'h2, 16'h0, 16'h0, 16'h3, 16'h1, 16'h0, 16'h1};

    dcc_channel u_dcc_channel (.MCLK(MCLK), .RST_B(RST_B), .CE(1'b1), .WB_ADR_I(wb_adr),
        .WB_DAT_I(wb_wd), .WB_DAT_O(wb_rd), .WB_SEL_I(4'hF), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc),
        .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack), .M_CYC_O(m_cyc), .M_STB_O(m_stb), .M_WE_O(m_we),
        .M_ADR_O(m_adr), .M_SEL_O(m_sel), .M_DAT_O(m_do), .M_DAT_I(m_di), .M_ACK_I(m_ack),
        .DREQ(dreq), .PEER_REQ(peer_req), .PEER_PRIO(peer_prio), .SYS_GNT(gnt), .BUS_REQ(breq),
        .BUS_LOCK(lock), .BUS_PRIO(prio_o), .IRQ(irq));
    dcc_mem_model u_dcc_mem_model (.MCLK(MCLK), .RST_B(RST_B), .CYC(m_cyc), .STB(m_stb),
        .ADR(m_adr), .DLY(r[5:4]), .ACK(m_ack), .DAT(m_di));

    // 40 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    function automatic logic [31:0] lf(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lf
    function automatic logic [31:0] msk(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : msk
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // bus monitor: logs acked accesses, checks lanes and data, counts irq, gaps, unlocked cycles
    always @(posedge MCLK) begin
        r <= lf(r);
        gnt <= r[2] | r[3];
        lcyc <= m_cyc;
        if (m_cyc === 1'b1 && m_stb === 1'b1 && m_ack === 1'b1) begin
            `CHK(m_sel, (wd == 2'h2) ? 4'hF : ((wd[0] ? 4'h3 : 4'h1) << m_adr[1:0]))
            if (m_we === 1'b1) begin
                wq.push_back(m_adr);
                `CHK(m_do & msk(m_sel), {4{lrd[7:0] ^ 8'h5A}} & msk(m_sel))
            end else begin
                rq.push_back(m_adr);
                lrd = m_adr;
            end
        end
        if (lcyc === 1'b1 && m_cyc === 1'b0) falls++;
        if (m_cyc === 1'b1 && lock !== 1'b1) nolock++;
        if (irq === 1'b1) irq_n++;
        // watchdog last, so nothing runs after the report
        cyc_n++;
        if (cyc_n == 40000) begin
            failures++;
            final_report();
        end
    end
    // classic single cycle: hold the request until ack is sampled, then release a cycle
    task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d,
                      output logic [15:0] o);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_wd  <= {16'h0000, d};
        do begin
            @(posedge MCLK);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) failures++;
        o = wb_rd[15:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge MCLK);
    endtask : wb
    // one programmed transfer; pb names peers that must hold the channel off
    task automatic xfer(input logic [15:0] c, input logic [15:0] n, input logic [15:0] t,
                        input logic [7:0] pb);
        logic [31:0] s, d;
        int i, j, m, st;
        s = {r[31:2], 2'b00};
        d = {r[29:0], 2'b00} ^ 32'h0000_1000;
        wd = c[2:1];
        st = 1 << c[2:1];
        wb(1'b1, 6'h00, s[15:0], q);
        wb(1'b1, 6'h08, s[31:16], q);
        wb(1'b1, 6'h10, d[15:0], q);
        wb(1'b1, 6'h18, d[31:16], q);
        wb(1'b1, 6'h20, t, q);
        wb(1'b1, 6'h28, n, q);
        peer_prio <= {c[10:8], c[10:8], c[10:8] + 3'h1, {5{c[10:8]}}};
        peer_req <= pb | 8'h08;
        rq.delete();
        wq.delete();
        irq_n = 0;
        falls = 0;
        nolock = 0;
        wb(1'b1, 6'h30, c, q);
        repeat (20) @(posedge MCLK);
        `CHK(prio_o, c[10:8])
        if (pb != 8'h00) `CHK(wq.size() + rq.size(), 0)
        if (pb != 8'h00) `CHK(breq, 1'b1)
        peer_req <= 8'h08;
        dreq <= c[4] & ~c[13];
        for (i = 0; c[13] && i <= n; i++) begin
            dreq <= 1'b1;
            repeat (24) @(posedge MCLK);
            if (i == 0) `CHK(wq.size(), 1)
            dreq <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
        if (c[7]) begin
            repeat (80) @(posedge MCLK);
            dreq <= 1'b0;
            repeat (20) @(posedge MCLK);
            wb(1'b0, 6'h30, 16'h0000, q);
            `CHK(q[0], 1'b1)
            `CHK(wq.size() > n + 1, 1'b1)
            wb(1'b1, 6'h30, c & 16'hFFFE, q);
        end
        i = 0;
        do begin
            wb(1'b0, 6'h30, 16'h0000, q);
            i++;
        end while (q[0] !== 1'b0 && i < 200);
        dreq <= 1'b0;
        `CHK(q[0], 1'b0)
        j = wq.size();
        for (m = 0; m < j; m++) begin
            i = m % (n + 1);
            if (i == 0 || !c[12]) begin
                e = rq.pop_front();
                `CHK(e, s + (c[6] ? i * st : 0))
            end
            e = wq.pop_front();
            `CHK(e, d + (c[5] ? i * st : 0))
        end
        if (!c[7]) begin
            `CHK(j + rq.size(), n + 1)
            `CHK(irq_n, int'(c[3] && t <= n))
            `CHK(falls, (c[4] || (c[11] && !c[12])) ? n + 1 : 1)
            wb(1'b0, 6'h38, 16'h0000, q);
            `CHK(q, 16'h0000)
            `CHK(breq, 1'b0)
        end
        if (!c[4] && (c[12] || !c[11])) `CHK(nolock, 0)
    endtask : xfer
    // main sequence: registers first, then the transfer table
    initial begin
        RST_B = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 6'h00;
        wb_wd = 32'h0000_0000;
        dreq = 1'b0;
        gnt = 1'b0;
        peer_req = 8'h00;
        peer_prio = 24'h000000;
        wd = 2'h0;
        r = 32'd86433;
        repeat (8) @(posedge MCLK);
        RST_B <= 1'b1;
        @(posedge MCLK);
        for (k = 0; k < 16; k++) begin
            wb(1'b0, 6'(k * 4), 16'h0000, q);
            `CHK(q, 16'h0000)
        end
        for (k = 0; k < 6; k++) begin
            v = r[15:0];
            wb(1'b1, 6'(k * 8), v, q);
            wb(1'b0, 6'(k * 8), 16'h0000, q);
            `CHK(q, v)
        end
        wb(1'b1, 6'h30, 16'hFFFE, q);
        wb(1'b0, 6'h30, 16'h0000, q);
        `CHK(q, 16'h3FFE)
        wb(1'b1, 6'h38, 16'h1234, q);
        wb(1'b0, 6'h38, 16'h0000, q);
        `CHK(q, 16'h0000)
        // fill entry steps the destination and is never paced
        for (k = 0; k < 7; k++) xfer(c_t[k], n_t[k], t_t[k], (k < 2) ? (8'h01 << (5 * k)) : 8'h00);
        final_report();
    end
endmodule : dcc_channel_tb_top
`default_nettype wire
